// >>> rtl/tcd_regs.svh
`ifndef TCD_REGS_SVH
`define TCD_REGS_SVH
// Channel block select and register index inside a block
`define TCD_CH_BIT     5
`define TCD_IDX_CTRL   3'h0
`define TCD_IDX_SRC    3'h1
`define TCD_IDX_DST    3'h2
`define TCD_IDX_RLD    3'h3
`define TCD_IDX_CNT    3'h4
`define TCD_IDX_SEL    3'h5
`define TCD_IDX_FWD    3'h6
`define TCD_IDX_NONE   3'h7
// Control register bit positions
`define TCD_CTL_EN     0
`define TCD_CTL_REQ    1
`define TCD_CTL_BYTE   2
`define TCD_CTL_RPT    3
`define TCD_CTL_SINC   4
`define TCD_CTL_DINC   5
`define TCD_CTL_SWRQ   6
// Reset values
`define TCD_RST_PTR    20'h00000
`define TCD_RST_CNT    16'h0000
`define TCD_RST_SEL    5'h00
// Own register window, never touched by a transfer
`define TCD_OWN_LO     20'h00020
`define TCD_OWN_HI     20'h0003f
// Request source select codes; code 0 is software only
`define TCD_EV_PIN1F   1
`define TCD_EV_PIN1B   2
`define TCD_EV_PIN2F   3
`define TCD_EV_PERI    4
`endif

// >>> rtl/tcd_pkg.sv
package tcd_pkg;
    // Transfer engine states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_READ  = 3'b010,
        ST_WRITE = 3'b100
    } tcd_state_t;
    // Address in the 1M byte space
    typedef logic [19:0] tcd_addr_t;
endpackage

// >>> rtl/tcd_ch_if.sv
`timescale 1ns/1ns
interface tcd_ch_if;
    logic               wr;        // Register write strobe
    logic [2:0]         idx;       // Register index
    logic [31:0]        wdata;
    logic [31:0]        wmask;     // Byte lanes expanded to bits
    logic [31:0]        rdata;
    logic [31:0]        events;    // Source pulses by select code
    logic               grant;     // Transfer starts this cycle
    logic               done;      // Unit finished this cycle
    logic               pend;
    logic               byte_unit;
    tcd_pkg::tcd_addr_t src;
    tcd_pkg::tcd_addr_t dst;
    logic               uflow;     // Counter underflow pulse
    modport eng (output wr, idx, wdata, wmask, events, grant, done,
                 input rdata, pend, byte_unit, src, dst, uflow);
    modport chan (input wr, idx, wdata, wmask, events, grant, done,
                  output rdata, pend, byte_unit, src, dst, uflow);
endinterface

// >>> rtl/tcd_channel.sv
`timescale 1ns/1ns
`include "tcd_regs.svh"
module tcd_channel (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Engine side
    tcd_ch_if.chan   ch
);
    logic               en_q, flag_q, byte_q, rpt_q, sinc_q, dinc_q;
    logic               first_q, uflow_q;
    tcd_pkg::tcd_addr_t src_q, dst_q, fwd_q;
    logic [15:0]        rld_q, cnt_q;
    logic [4:0]         sel_q;
    logic [31:0]        wv;
    logic               wr_ctl, sw_req, trig, en_wr;

    // Byte-lane merge of the write into the current contents
    assign wv     = (ch.rdata & ~ch.wmask) | (ch.wdata & ch.wmask);
    assign wr_ctl = ch.wr && ch.idx == `TCD_IDX_CTRL;
    assign en_wr  = wr_ctl && ch.wmask[`TCD_CTL_EN];
    assign sw_req = wr_ctl && ch.wmask[`TCD_CTL_SWRQ]
                    && ch.wdata[`TCD_CTL_SWRQ];
    assign trig   = sw_req | ch.events[sel_q];

    // Request flag: set wins over both clears
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            flag_q <= 1'b0;
        end else if (trig) begin
            flag_q <= 1'b1;
        end else if (ch.grant) begin
            flag_q <= 1'b0;
        end else if (wr_ctl && ch.wmask[`TCD_CTL_REQ]
                     && !ch.wdata[`TCD_CTL_REQ]) begin
            flag_q <= 1'b0;
        end
    end

    // Mode bits; both directions incrementing is refused
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            byte_q <= 1'b0;
            rpt_q  <= 1'b0;
            sinc_q <= 1'b0;
            dinc_q <= 1'b0;
            sel_q  <= `TCD_RST_SEL;
        end else begin
            if (wr_ctl) begin
                byte_q <= wv[`TCD_CTL_BYTE];
                rpt_q  <= wv[`TCD_CTL_RPT];
                sinc_q <= wv[`TCD_CTL_SINC];
                dinc_q <= wv[`TCD_CTL_DINC] & ~wv[`TCD_CTL_SINC];
            end
            if (ch.wr && ch.idx == `TCD_IDX_SEL) begin
                sel_q <= wv[4:0];
            end
        end
    end

    // Enable and restart; a software write lands after the underflow stop
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            en_q    <= 1'b0;
            first_q <= 1'b0;
        end else begin
            if (ch.done && cnt_q == 16'h0000 && !rpt_q) begin
                en_q <= 1'b0;
            end
            if (ch.grant) begin
                first_q <= 1'b0;
            end
            if (en_wr) begin
                en_q    <= ch.wdata[`TCD_CTL_EN];
                first_q <= ch.wdata[`TCD_CTL_EN];
            end
        end
    end

    // Pointers: fixed-side ones are locked while enabled
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            src_q <= `TCD_RST_PTR;
            dst_q <= `TCD_RST_PTR;
            rld_q <= `TCD_RST_CNT;
        end else if (ch.wr) begin
            if (ch.idx == `TCD_IDX_SRC && (sinc_q || !en_q)) begin
                src_q <= wv[19:0];
            end
            if (ch.idx == `TCD_IDX_DST && (dinc_q || !en_q)) begin
                dst_q <= wv[19:0];
            end
            if (ch.idx == `TCD_IDX_RLD) begin
                rld_q <= wv[15:0];
            end
        end
    end

    // Forward pointer and counter; loaded at first grant after enable
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fwd_q   <= `TCD_RST_PTR;
            cnt_q   <= `TCD_RST_CNT;
            uflow_q <= 1'b0;
        end else begin
            uflow_q <= ch.done && cnt_q == 16'h0000;
            if (ch.grant && first_q) begin
                fwd_q <= sinc_q ? src_q : dst_q;
                cnt_q <= rld_q;
            end else if (ch.done) begin
                fwd_q <= fwd_q + (byte_q ? 20'h00001 : 20'h00002);
                if (cnt_q != 16'h0000) begin
                    cnt_q <= cnt_q - 16'h0001;
                end else if (rpt_q) begin
                    cnt_q <= rld_q;
                end
            end
        end
    end

    // Addresses seen by the engine at grant
    always_comb begin
        ch.src = src_q;
        ch.dst = dst_q;
        if (sinc_q) begin
            ch.src = first_q ? src_q : fwd_q;
        end
        if (dinc_q) begin
            ch.dst = first_q ? dst_q : fwd_q;
        end
    end

    assign ch.pend      = en_q & flag_q;
    assign ch.byte_unit = byte_q;
    assign ch.uflow     = uflow_q;

    // Every register readable in any state
    always_comb begin
        unique case (ch.idx)
            `TCD_IDX_CTRL: ch.rdata = {26'h0, dinc_q, sinc_q, rpt_q,
                                       byte_q, flag_q, en_q};
            `TCD_IDX_SRC:  ch.rdata = {12'h0, src_q};
            `TCD_IDX_DST:  ch.rdata = {12'h0, dst_q};
            `TCD_IDX_RLD:  ch.rdata = {16'h0, rld_q};
            `TCD_IDX_CNT:  ch.rdata = {16'h0, cnt_q};
            `TCD_IDX_SEL:  ch.rdata = {27'h0, sel_q};
            `TCD_IDX_FWD:  ch.rdata = {12'h0, fwd_q};
            default:       ch.rdata = 32'h0;
        endcase
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    req_set_a: assert property (
        trig |=> flag_q)
        else $error("request flag missed a trigger");
    req_clear_a: assert property (
        ch.grant && !trig |=> !flag_q)
        else $error("request flag not cleared at transfer start");
    single_stop_a: assert property (
        ch.done && cnt_q == 16'h0000 && !rpt_q && !en_wr |=> !en_q)
        else $error("single mode stayed enabled after underflow");
    repeat_reload_a: assert property (
        ch.done && cnt_q == 16'h0000 && rpt_q && !en_wr
        |=> en_q && cnt_q == $past(rld_q))
        else $error("repeat mode did not reload");
    first_load_a: assert property (
        ch.grant && first_q && !en_wr |=> cnt_q == $past(rld_q) && !first_q)
        else $error("counter not loaded at first transfer");
    fixed_lock_a: assert property (
        en_q && !sinc_q |=> src_q == $past(src_q) || !$past(en_q))
        else $error("fixed source pointer changed while enabled");
    done_irq_a: assert property (
        ch.done && cnt_q == 16'h0000 |=> uflow_q ##1 !uflow_q)
        else $error("underflow pulse missing");
    merge_c: cover property (flag_q && trig);
    repeat_c: cover property (ch.done && cnt_q == 16'h0000 && rpt_q);
endmodule

// >>> rtl/tcd_dma.sv
`timescale 1ns/1ns
`include "tcd_regs.svh"
// Summary of operation
// - Two channels steal single bus cycles
// - Software bit or selected source requests
// - Interrupt masks ignored, interrupt lines untouched
// - Enabled channel transfers per request, else idle
// - Requests arriving early merge into one
// - Inc-to-fixed, fixed-to-inc, fixed-to-fixed addressing
// - Own register window never read or written
// - Counter allows up to 64K units
// - Pins, timers, serial, I2C, ADC, display sources
// - Channel zero wins simultaneous requests
// - Unit is one byte or one word
// - Single mode underflow clears enable
// - Repeat mode underflow reloads counter, stays on
// - First transfer loads pointer and counter
// - Fixed-side pointers writable only while disabled
// - All registers readable at any time
// - Request flag: hardware sets, start or software clears
// - Rewriting enable restarts from initial state
module tcd_dma #(
    parameter int NUM_PERIPH = 19
) (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    // Wishbone register slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output wire logic [31:0]           wb_dat_o,
    output wire logic                  wb_ack_o,
    // Request sources
    input  wire logic                  ext_irq_pin_one,
    input  wire logic                  ext_irq_pin_two,
    input  wire logic [NUM_PERIPH-1:0] periph_irq,
    // Shared memory bus, owned over the CPU while bus_req_o is high
    output wire logic                  bus_req_o,
    output wire logic                  mem_cyc_o,
    output wire logic                  mem_we_o,
    output wire logic [19:0]           mem_adr_o,
    output wire logic [1:0]            mem_sel_o,
    output wire logic [15:0]           mem_dat_o,
    input  wire logic [15:0]           mem_dat_i,
    input  wire logic                  mem_ack_i,
    // Completion pulses, one per channel
    output wire logic [1:0]            done_irq
);
    // Select code is five bits wide
    // Codes 0 to 3 are taken by software and the pins
    if (NUM_PERIPH < 1 || NUM_PERIPH > 27) begin : g_chk
        $error("NUM_PERIPH must be 1 to 27");
    end

    tcd_ch_if chif [2] ();

    tcd_pkg::tcd_state_t state_q;
    logic                chn_q, chn_d;
    logic                byte_q, cyc_q, we_q, ack_q;
    tcd_pkg::tcd_addr_t  adr_q, dst_q;
    tcd_pkg::tcd_addr_t  src_mux, dst_mux;
    logic                byte_mux;
    logic [1:0]          sel_q;
    logic [15:0]         dat_q, rv, wv;
    logic [7:0]          rb;
    logic [31:0]         rd_q, wmask, events;
    logic [31:0]         rdat [2];
    logic                p1_q, p2_q;
    logic [1:0]          pend;
    logic                access, mapped, start, rdone, finish;

    // Address falls inside our own register window
    function automatic logic own_range(input tcd_pkg::tcd_addr_t a);
        own_range = (a >= `TCD_OWN_LO) && (a <= `TCD_OWN_HI);
    endfunction

    // Byte lanes for one unit at an address
    function automatic logic [1:0] lanes(input tcd_pkg::tcd_addr_t a,
                                         input logic b);
        lanes = !b ? 2'b11 : (a[0] ? 2'b10 : 2'b01);
    endfunction

    // Previous pin levels; idle high so reset gives no false edge
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            p1_q <= 1'b1;
            p2_q <= 1'b1;
        end else begin
            p1_q <= ext_irq_pin_one;
            p2_q <= ext_irq_pin_two;
        end
    end

    // Source pulses by select code; only observed, never cleared
    always_comb begin
        events = 32'h0;
        events[`TCD_EV_PIN1F] = p1_q & ~ext_irq_pin_one;
        events[`TCD_EV_PIN1B] = p1_q ^ ext_irq_pin_one;
        events[`TCD_EV_PIN2F] = p2_q & ~ext_irq_pin_two;
        events[`TCD_EV_PERI +: NUM_PERIPH] = periph_irq;
    end

    // Wishbone decode; unmapped words ack with zero data
    assign access = wb_cyc_i & wb_stb_i & ~ack_q;
    assign mapped = wb_adr_i[7:6] == 2'b00
                    && wb_adr_i[4:2] != `TCD_IDX_NONE;
    assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // One wait state, ack drops the cycle after it was given
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access;
        end
    end

    // Read data caught with the request
    // Held until the next read, so a slow master still sees it
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_q <= 32'h0;
        end else if (access && !wb_we_i) begin
            rd_q <= mapped ? rdat[wb_adr_i[`TCD_CH_BIT]] : 32'h0;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rd_q;

    // Two identical channels
    for (genvar i = 0; i < 2; i++) begin : g_ch
        assign chif[i].wr     = access & wb_we_i & mapped
                                & (wb_adr_i[`TCD_CH_BIT] == 1'(i));
        assign chif[i].idx    = wb_adr_i[4:2];
        assign chif[i].wdata  = wb_dat_i;
        assign chif[i].wmask  = wmask;
        assign chif[i].events = events;
        assign chif[i].grant  = start & (chn_d == 1'(i));
        assign chif[i].done   = finish & (chn_q == 1'(i));
        assign pend[i]        = chif[i].pend;
        assign rdat[i]        = chif[i].rdata;
        assign done_irq[i]    = chif[i].uflow;
        tcd_channel u_ch (
            .ref_clk (ref_clk),
            .nrst    (nrst),
            .ch      (chif[i])
        );
    end

    // Fixed priority: channel zero first
    assign chn_d    = ~pend[0];
    assign src_mux  = chn_d ? chif[1].src : chif[0].src;
    assign dst_mux  = chn_d ? chif[1].dst : chif[0].dst;
    assign byte_mux = chn_d ? chif[1].byte_unit : chif[0].byte_unit;

    // A skipped cycle ends at once, so a refused unit still completes
    assign start  = state_q == tcd_pkg::ST_IDLE && |pend;
    assign rdone  = state_q == tcd_pkg::ST_READ && (!cyc_q || mem_ack_i);
    assign finish = state_q == tcd_pkg::ST_WRITE && (!cyc_q || mem_ack_i);

    // Engine sequence: read one unit, write it, release the bus
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= tcd_pkg::ST_IDLE;
            chn_q   <= 1'b0;
        end else begin
            unique case (state_q)
                tcd_pkg::ST_IDLE: begin
                    if (start) begin
                        state_q <= tcd_pkg::ST_READ;
                        chn_q   <= chn_d;
                    end
                end
                tcd_pkg::ST_READ: begin
                    if (rdone) begin
                        state_q <= tcd_pkg::ST_WRITE;
                    end
                end
                tcd_pkg::ST_WRITE: begin
                    if (finish) begin
                        state_q <= tcd_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= tcd_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Read value; a skipped own-window read yields zero
    assign rv = cyc_q ? mem_dat_i : 16'h0;
    assign rb = adr_q[0] ? rv[15:8] : rv[7:0];
    assign wv = byte_q ? {rb, rb} : rv;

    // Cycle request; own window accesses are skipped, not issued
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cyc_q <= 1'b0;
            we_q  <= 1'b0;
        end else if (start) begin
            cyc_q <= !own_range(src_mux);
            we_q  <= 1'b0;
        end else if (rdone) begin
            cyc_q <= !own_range(dst_q);
            we_q  <= 1'b1;
        end else if (finish) begin
            cyc_q <= 1'b0;
            we_q  <= 1'b0;
        end
    end

    // Address and lanes: source first, then destination
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            adr_q <= `TCD_RST_PTR;
            sel_q <= 2'b00;
        end else if (start) begin
            adr_q <= src_mux;
            sel_q <= lanes(src_mux, byte_mux);
        end else if (rdone) begin
            adr_q <= dst_q;
            sel_q <= lanes(dst_q, byte_q);
        end
    end

    // Write data held from the read ack until the write ack
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dat_q <= 16'h0;
        end else if (rdone) begin
            dat_q <= wv;
        end
    end

    // Destination and unit size latched at grant; the channel may
    // move its pointers while the unit is still in flight
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dst_q  <= `TCD_RST_PTR;
            byte_q <= 1'b0;
        end else if (start) begin
            dst_q  <= dst_mux;
            byte_q <= byte_mux;
        end
    end

    assign bus_req_o = state_q != tcd_pkg::ST_IDLE;
    assign mem_cyc_o = cyc_q;
    assign mem_we_o  = we_q;
    assign mem_adr_o = adr_q;
    assign mem_sel_o = sel_q;
    assign mem_dat_o = dat_q;

    // Engine checks, all on the bus clock
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    prio_ch0_a: assert property (
        state_q == tcd_pkg::ST_IDLE && &pend |=> chn_q == 1'b0)
        else $error("channel one won a simultaneous request");
    own_range_a: assert property (
        mem_cyc_o |-> !own_range(mem_adr_o))
        else $error("transfer reached the own register window");
    steal_one_a: assert property (
        finish |=> !bus_req_o)
        else $error("bus not released after one unit");
    idle_quiet_a: assert property (
        state_q == tcd_pkg::ST_IDLE && pend == 2'b00
        |=> !mem_cyc_o && !bus_req_o)
        else $error("bus used with nothing pending");
    unit_lanes_a: assert property (
        mem_cyc_o |-> (byte_q ? mem_sel_o != 2'b11 : mem_sel_o == 2'b11))
        else $error("byte lanes disagree with the unit size");
    write_dest_a: assert property (
        rdone |=> mem_we_o && mem_adr_o == $past(dst_q))
        else $error("write did not go to the destination");
    start_read_a: assert property (
        start |=> state_q == tcd_pkg::ST_READ && !mem_we_o)
        else $error("transfer did not begin with a read");
    bus_owner_a: assert property (
        mem_cyc_o |-> bus_req_o)
        else $error("memory cycle without bus ownership");
    read_then_write_a: assert property (
        rdone |=> state_q == tcd_pkg::ST_WRITE)
        else $error("read not followed by a write");
    skip_zero_a: assert property (
        rdone && !cyc_q |=> mem_dat_o == 16'h0)
        else $error("skipped read did not yield zero");
    both_c: cover property (&pend && state_q == tcd_pkg::ST_IDLE);
    skip_c: cover property (state_q == tcd_pkg::ST_WRITE && !cyc_q);
    byte_c: cover property (mem_cyc_o && mem_we_o && byte_q);
endmodule

// >>> tb/tcd_mem_model.sv
`timescale 1ns/1ns
// Shared memory on the stolen bus, with optional wait states
module tcd_mem_model (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // Wait control from the bench
    input  wire logic        slow,
    // Memory bus
    input  wire logic        mem_cyc_o,
    input  wire logic        mem_we_o,
    input  wire logic [19:0] mem_adr_o,
    input  wire logic [1:0]  mem_sel_o,
    input  wire logic [15:0] mem_dat_o,
    output wire logic [15:0] mem_dat_i,
    output logic             mem_ack_i
);
    logic [15:0] mem [0:255];
    logic [15:0] rd_q;
    logic [1:0]  wt_q;
    // Inverted data off the ack cycle, so stale data is never trusted
    assign mem_dat_i = mem_ack_i ? rd_q : ~rd_q;
    // One-cycle ack after zero or two wait cycles; write at the ack edge
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mem_ack_i <= 1'b0;
            wt_q      <= 2'h0;
        end else if (mem_cyc_o && !mem_ack_i && wt_q >= {slow, 1'b0}) begin
            mem_ack_i <= 1'b1;
            wt_q      <= 2'h0;
            rd_q      <= mem[mem_adr_o[8:1]];
            if (mem_we_o && mem_sel_o[0])
                mem[mem_adr_o[8:1]][7:0] <= mem_dat_o[7:0];
            if (mem_we_o && mem_sel_o[1])
                mem[mem_adr_o[8:1]][15:8] <= mem_dat_o[15:8];
        end else begin
            mem_ack_i <= 1'b0;
            if (mem_cyc_o && !mem_ack_i)
                wt_q <= wt_q + 2'h1;
        end
    end
endmodule

// >>> tb/tcd_dma_tb.sv
`timescale 1ns/1ns
module tcd_dma_tb;
    logic        ref_clk, nrst = 1'b0, cyc = 1'b0, we = 1'b0;
    logic        pin1 = 1'b1, pin2 = 1'b1, slow = 1'b0, got_rd = 1'b0;
    logic        clr = 1'b0;
    logic        wb_ack_o, bus_req_o, mem_cyc_o, mem_we_o, mem_ack_i;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
    logic [18:0] periph_irq = 19'h0;
    logic [19:0] mem_adr_o, first_adr;
    logic [1:0]  mem_sel_o, done_irq, done_seen = 2'h0;
    logic [15:0] mem_dat_o, mem_dat_i;
    int          err_count = 0, n_compared = 0;
    tcd_dma u_dut (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ext_irq_pin_one(pin1), .ext_irq_pin_two(pin2),
        .periph_irq(periph_irq), .bus_req_o(bus_req_o),
        .mem_cyc_o(mem_cyc_o), .mem_we_o(mem_we_o), .mem_adr_o(mem_adr_o),
        .mem_sel_o(mem_sel_o), .mem_dat_o(mem_dat_o),
        .mem_dat_i(mem_dat_i), .mem_ack_i(mem_ack_i), .done_irq(done_irq));
    tcd_mem_model u_mem (.ref_clk(ref_clk), .nrst(nrst), .slow(slow),
        .mem_cyc_o(mem_cyc_o), .mem_we_o(mem_we_o), .mem_adr_o(mem_adr_o),
        .mem_sel_o(mem_sel_o), .mem_dat_o(mem_dat_o),
        .mem_dat_i(mem_dat_i), .mem_ack_i(mem_ack_i));
    // Free-running clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Sticky done flags, first read address, own window watch
    always @(posedge ref_clk) begin
        if (clr) begin
            done_seen <= 2'h0;
            got_rd    <= 1'b0;
        end else begin
            done_seen <= done_seen | done_irq;
            if (mem_cyc_o && !mem_we_o && !got_rd) begin
                first_adr <= mem_adr_o;
                got_rd    <= 1'b1;
            end
        end
        if (mem_cyc_o && mem_adr_o >= 20'h00020 && mem_adr_o <= 20'h0003f)
            fail("own window touched");
    end
    task automatic fail(input string m);
        err_count++;
        $display("Error at %0t: %s", $time, m);
    endtask
    task automatic cmp(input logic [31:0] got, exp, input string m);
        n_compared++;
        if (got !== exp)
            fail(m);
    endtask
    task automatic final_report();
        if (err_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Classic cycle: hold until ack is sampled, then release
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        @(posedge ref_clk);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 20) begin
            fail("register bus timeout");
            final_report();
        end
        rdat = wb_dat_o;
        cyc <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 32'h0);
    endtask
    // Clear watch flags for one edge, then a one-cycle pulse on both pins or on periph_irq[0]
    task automatic pulse(input logic pin);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        if (pin) begin
            pin1 <= 1'b0;
            pin2 <= 1'b0;
        end else begin
            periph_irq[0] <= 1'b1;
        end
        @(posedge ref_clk);
        pin1       <= 1'b1;
        pin2       <= 1'b1;
        periph_irq <= 19'h0;
    endtask
    // Bounded wait for an idle bus and the expected done pulses
    task automatic wt(input logic [1:0] m);
        int n;
        n = 0;
        while (!(bus_req_o === 1'b0 && (done_seen & m) === m &&
                 (m != 2'h0 || got_rd)) && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 200) begin
            fail("transfer timeout");
            final_report();
        end
    endtask
    task automatic s_regs();
        rd(8'h00);
        cmp(rdat, 32'h0, "control reset");
        wr(8'h3c, 32'h5);
        rd(8'h3c);
        cmp(rdat, 32'h0, "unmapped read");
        wr(8'h20, 32'h40);
        rd(8'h20);
        cmp(rdat, 32'h2, "flag while off");
        cmp({31'h0, got_rd}, 32'h0, "moved while off");
        wr(8'h20, 32'h0);
        rd(8'h20);
        cmp(rdat, 32'h0, "flag clear");
        wr(8'h34, 32'h3);
        pulse(1'b1);
        rd(8'h20);
        cmp(rdat, 32'h2, "pin two flag");
        wr(8'h20, 32'h0);
    endtask
    task automatic s_single();
        u_mem.mem[8'h80] = 16'h1111;
        u_mem.mem[8'h81] = 16'h2222;
        wr(8'h04, 32'h100);
        wr(8'h08, 32'h180);
        wr(8'h0c, 32'h1);
        wr(8'h14, 32'h4);
        wr(8'h00, 32'h11);
        wr(8'h08, 32'h1a0);
        rd(8'h08);
        cmp(rdat, 32'h180, "fixed pointer locked");
        pulse(1'b0);
        wt(2'h0);
        cmp({16'h0, u_mem.mem[8'hc0]}, 32'h1111, "first unit");
        rd(8'h18);
        cmp(rdat, 32'h102, "pointer step");
        wr(8'h04, 32'h120);
        rd(8'h04);
        cmp(rdat, 32'h120, "moving pointer writable");
        pulse(1'b0);
        wt(2'h1);
        cmp({16'h0, u_mem.mem[8'hc0]}, 32'h2222, "second unit");
        rd(8'h00);
        cmp({31'h0, rdat[0]}, 32'h0, "single stop");
    endtask
    task automatic s_prio();
        u_mem.mem[8'h88] = 16'h3344;
        u_mem.mem[8'h89] = 16'h7788;
        u_mem.mem[8'ha0] = 16'h5566;
        u_mem.mem[8'he0] = 16'h0000;
        wr(8'h04, 32'h110);
        wr(8'h08, 32'h190);
        wr(8'h0c, 32'h0);
        wr(8'h00, 32'h19);
        wr(8'h24, 32'h140);
        wr(8'h28, 32'h1c1);
        wr(8'h34, 32'h4);
        wr(8'h20, 32'h25);
        slow <= 1'b1;
        pulse(1'b0);
        wt(2'h3);
        slow <= 1'b0;
        cmp({12'h0, first_adr}, 32'h110, "channel order");
        cmp({16'h0, u_mem.mem[8'hc8]}, 32'h3344, "word unit");
        cmp({16'h0, u_mem.mem[8'he0]}, 32'h6600, "byte lane");
        rd(8'h00);
        cmp({31'h0, rdat[0]}, 32'h1, "repeat stays on");
        rd(8'h38);
        cmp(rdat, 32'h1c2, "byte step");
        wr(8'h0c, 32'h3);
        pulse(1'b0);
        wt(2'h1);
        cmp({16'h0, u_mem.mem[8'hc8]}, 32'h7788, "fwd kept");
        rd(8'h10);
        cmp(rdat, 32'h3, "repeat reload");
    endtask
    task automatic s_own();
        u_mem.mem[8'hc8] = 16'hbeef;
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h30);
        wr(8'h0c, 32'h0);
        wr(8'h14, 32'h1);
        wr(8'h00, 32'h1);
        pulse(1'b1);
        wt(2'h1);
        cmp({16'h0, u_mem.mem[8'hc8]}, 32'h0, "own window read");
    endtask
    // Reset, scenarios, verdict
    initial begin
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        s_regs();
        s_single();
        s_prio();
        s_own();
        final_report();
    end
endmodule
